// File: logic/rfx_pkg.sv
package rfx_pkg;
	typedef logic [31:0] rfx_word_t;
	typedef logic [4:0]  rfx_radr_t;

	// Device variants, chosen by software
	typedef enum logic [1:0] {
		RFX_VAR_BASE = 2'b00,
		RFX_VAR_FP   = 2'b01,
		RFX_VAR_EXT  = 2'b10
	} rfx_var_e;

	// APB register offsets
	localparam logic [11:0] RFX_OFF_CFG    = 12'h000;
	localparam logic [11:0] RFX_OFF_STATUS = 12'h004;
	localparam logic [11:0] RFX_OFF_STALLS = 12'h008;
	localparam logic [1:0]  RFX_CFG_RST    = 2'h0;

	// Control register file indices
	localparam logic [3:0] RFX_CR_ADDR_MODE  = 4'h0;
	localparam logic [3:0] RFX_CR_CSR        = 4'h1;
	localparam logic [3:0] RFX_CR_INT_FLAG   = 4'h2;
	localparam logic [3:0] RFX_CR_INT_SET    = 4'h3;
	localparam logic [3:0] RFX_CR_INT_CLEAR  = 4'h4;
	localparam logic [3:0] RFX_CR_INT_ENABLE = 4'h5;
	localparam logic [3:0] RFX_CR_SVC_TABLE  = 4'h6;
	localparam logic [3:0] RFX_CR_MASK_RET   = 4'h7;
	localparam logic [3:0] RFX_CR_NMASK_RET  = 4'h8;
	localparam logic [3:0] RFX_CR_EXEC_PC    = 4'h9;

	// Status word field positions
	localparam int RFX_CSR_SATURATE    = 9;
	localparam int RFX_CSR_PREV_INT_EN = 1;
	localparam int RFX_CSR_INT_EN      = 0;
	localparam logic [15:0] RFX_CSR_ID = 16'h0000; // Arbitrary value

	// Cross path eligibility per unit within a side: bit0 logic,
	// bit1 shift, bit2 multiply, bit3 data
	localparam logic [3:0] RFX_X1_OK   = 4'h1;
	localparam logic [3:0] RFX_X2_BASE = 4'h7;
	localparam logic [3:0] RFX_X2_EXT  = 4'hf;
endpackage

// File: logic/rfx_core.sv
`timescale 1ns/1ps
// How it works
// - Side A units write only file A, side B units only file B.
// - Two cross paths carry one 32-bit operand from the opposite file.
// - Base/fp: logic either source, multiply/shift second only, data none.
// - Extended: all units cross on second source, logic on either.
// - One opposite-file read per side each cycle, two in total.
// - Extended: one cross operand is broadcast to every selecting unit.
// - Extended: cross read of a register written last cycle stalls one cycle.
// - No stall when that register was filled by a load.
// - Base: one 32-bit load path per side into its own file.
// - Fp adds a high load path; doubleword loads split low and high.
// - Extended: low and high load and store paths on each side.
// - Base/fp: one 32-bit store path per side from its file.
// - Both address paths reach both data units.
// - Transfer group picks the file, whichever data unit made the address.
// - Only the side B shift unit reaches the control register file.
// - Control registers are read and written by move-control.
// - An interrupt pin sets its flag bit without any instruction.
// - Taking an interrupt clears its flag and the global enable.
// - Return branch restores the global enable to its saved value.
// - Saturating operations set the saturation flag by hardware.
// - Interrupt set/clear writes change the flags one clock later.
// - Saturation flag set one cycle late; set beats a clear.
module rfx_core
(
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [11:0]                    paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic [7:0]                     unit_we,
	input  wire rfx_pkg::rfx_radr_t [7:0]       unit_waddr,
	input  wire rfx_pkg::rfx_word_t [7:0]       unit_wdata,
	input  wire rfx_pkg::rfx_radr_t [7:0]       first_source_addr,
	input  wire rfx_pkg::rfx_radr_t [7:0]       second_source_addr,
	input  wire logic [7:0]                     first_source_cross,
	input  wire logic [7:0]                     second_source_cross,
	output rfx_pkg::rfx_word_t [7:0]            first_source_data,
	output rfx_pkg::rfx_word_t [7:0]            second_source_data,
	output logic                                cross_stall,
	input  wire logic [1:0]                     load_valid,
	input  wire logic [1:0]                     load_double,
	input  wire rfx_pkg::rfx_radr_t [1:0]       load_addr,
	input  wire logic [1:0][63:0]               load_data,
	input  wire rfx_pkg::rfx_radr_t [1:0]       store_addr,
	input  wire logic [1:0]                     store_double,
	output logic      [1:0][63:0]               store_data,
	input  wire rfx_pkg::rfx_word_t [1:0]       data_unit_addr,
	input  wire logic [1:0]                     transfer_unit_sel,
	output rfx_pkg::rfx_word_t [1:0]            transfer_addr,
	input  wire logic                           move_control_wr,
	input  wire logic                           move_control_rd,
	input  wire logic [3:0]                     move_control_idx,
	input  wire logic [31:0]                    move_control_wdata,
	output logic      [31:0]                    move_control_rdata,
	input  wire logic [15:0]                    external_interrupt_pin,
	input  wire logic                           int_take,
	input  wire logic [3:0]                     int_take_num,
	input  wire logic                           return_from_interrupt_branch,
	input  wire logic                           saturation_event,
	input  wire logic [31:0]                    execute_stage_program_counter,
	output logic                                global_int_enable,
	output logic                                saturation_flag
);
	import rfx_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0]            variant;
		logic [1:0]            xerr;
		logic [31:0]           stalls;
		logic [1:0][31:0][31:0] rf;
		logic [1:0][31:0]      wmask;
		logic [7:0][31:0]      op1;
		logic [7:0][31:0]      op2;
		logic [1:0][63:0]      st_data;
		logic [1:0][31:0]      da;
		logic [31:0]           addr_mode;
		logic [31:0]           int_enables;
		logic [31:0]           svc_table;
		logic [31:0]           mask_ret;
		logic [31:0]           nmask_ret;
		logic [31:0]           mvc_rdata;
		logic [15:0]           int_flags;
		logic [15:0]           flag_set_pend;
		logic [15:0]           flag_clr_pend;
		logic                  int_en;
		logic                  prev_int_en;
		logic                  saturated;
		logic                  saturate_pend;
	} rfx_state_s;

	rfx_state_s st;
	rfx_state_s next_st;

	logic            is_ext;
	logic [7:0]      use1;
	logic [7:0]      use2;
	logic [1:0][4:0] xaddr;
	logic [1:0]      xany;
	logic [1:0]      xclash;
	logic [1:0][2:0] xcnt;
	logic [1:0][31:0] xbus;
	logic            stall;
	logic            apb_wr;
	logic            hit;
	logic [31:0]     csr_val;

	assign is_ext  = (st.variant == RFX_VAR_EXT);
	assign apb_wr  = psel & penable & pwrite;
	assign csr_val = {RFX_CSR_ID, 6'h00, st.saturated, 7'h00, st.prev_int_en, st.int_en};

	// ==========================================================
	// Cross path decode
	// Units that lack a cross port fall back to the own file
	always_comb
	begin
		use1   = '0;
		use2   = '0;
		xaddr  = '0;
		xany   = '0;
		xclash = '0;
		xcnt   = '0;
		for (int u = 0; u < 8; u++)
		begin
			use1[u] = first_source_cross[u] & RFX_X1_OK[u % 4];
			use2[u] = second_source_cross[u]
				& (is_ext ? RFX_X2_EXT[u % 4] : RFX_X2_BASE[u % 4]);
		end
		for (int s = 0; s < 2; s++)
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (use1[s*4+k])
				begin
					if (xany[s] && first_source_addr[s*4+k] != xaddr[s])
						xclash[s] = 1'b1;
					if (!xany[s])
						xaddr[s] = first_source_addr[s*4+k];
					xany[s] = 1'b1;
				end
				if (use2[s*4+k])
				begin
					if (xany[s] && second_source_addr[s*4+k] != xaddr[s])
						xclash[s] = 1'b1;
					if (!xany[s])
						xaddr[s] = second_source_addr[s*4+k];
					xany[s] = 1'b1;
				end
				xcnt[s] = xcnt[s] + {2'b00, use1[s*4+k] | use2[s*4+k]};
			end
			// Only base/fp forbid sharing between units
			if (!is_ext && xcnt[s] > 3'h1)
				xclash[s] = 1'b1;
			// A single read of the opposite file per side
			xbus[s] = st.rf[1-s][xaddr[s]];
		end
		// Hazard mask only holds unit writes, never loads
		stall = is_ext & ((xany[0] & st.wmask[1][xaddr[0]])
			| (xany[1] & st.wmask[0][xaddr[1]]));
	end

	// ==========================================================
	// APB read mux, zero wait states
	always_comb
	begin
		hit    = 1'b1;
		prdata = 32'h0000_0000;
		case (paddr)
			RFX_OFF_CFG:    prdata = {30'h0, st.variant};
			RFX_OFF_STATUS: prdata = {28'h0, st.saturated, st.int_en, st.xerr};
			RFX_OFF_STALLS: prdata = st.stalls;
			default:        hit = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// ==========================================================
	// Next state
	always_comb
	begin
		next_st       = st;
		next_st.wmask = '0;

		// Software configuration and sticky clash flags
		if (apb_wr && paddr == RFX_OFF_CFG)
			next_st.variant = pwdata[1:0];
		if (apb_wr && paddr == RFX_OFF_STATUS)
			next_st.xerr = st.xerr & ~pwdata[1:0];
		next_st.xerr = next_st.xerr | xclash;

		// Operands, unit writes and loads freeze for one cycle; store and address paths keep running; units hold their inputs
		if (stall)
			next_st.stalls = st.stalls + 32'h1;
		else
		begin
			for (int u = 0; u < 8; u++)
			begin
				// Broadcast of the one cross operand to every selector
				next_st.op1[u] = use1[u] ? xbus[u/4]
					: st.rf[u/4][first_source_addr[u]];
				next_st.op2[u] = use2[u] ? xbus[u/4]
					: st.rf[u/4][second_source_addr[u]];
				if (unit_we[u])
				begin
					next_st.rf[u/4][unit_waddr[u]]    = unit_wdata[u];
					next_st.wmask[u/4][unit_waddr[u]] = 1'b1;
				end
			end
			// Group g always lands in file g; loaded registers never stall
			for (int g = 0; g < 2; g++)
			begin
				if (load_valid[g] && load_double[g] && st.variant != RFX_VAR_BASE)
				begin
					next_st.rf[g][{load_addr[g][4:1], 1'b0}] = load_data[g][31:0];
					next_st.rf[g][{load_addr[g][4:1], 1'b1}] = load_data[g][63:32];
					next_st.wmask[g][{load_addr[g][4:1], 1'b0}] = 1'b0;
					next_st.wmask[g][{load_addr[g][4:1], 1'b1}] = 1'b0;
				end
				else if (load_valid[g])
				begin
					next_st.rf[g][load_addr[g]]    = load_data[g][31:0];
					next_st.wmask[g][load_addr[g]] = 1'b0;
				end
			end
		end

		// Store and address paths; high store half only on extended
		for (int g = 0; g < 2; g++)
		begin
			if (is_ext && store_double[g])
				next_st.st_data[g] = {st.rf[g][{store_addr[g][4:1], 1'b1}],
					st.rf[g][{store_addr[g][4:1], 1'b0}]};
			else
				next_st.st_data[g] = {32'h0, st.rf[g][store_addr[g]]};
			next_st.da[g] = data_unit_addr[transfer_unit_sel[g]];
		end

		// Control register file, side B shift unit port only
		next_st.flag_set_pend = '0;
		next_st.flag_clr_pend = '0;
		next_st.saturate_pend = saturation_event;
		if (move_control_rd)
		begin
			case (move_control_idx)
				RFX_CR_ADDR_MODE:  next_st.mvc_rdata = st.addr_mode;
				RFX_CR_CSR:        next_st.mvc_rdata = csr_val;
				RFX_CR_INT_FLAG:   next_st.mvc_rdata = {16'h0, st.int_flags};
				RFX_CR_INT_ENABLE: next_st.mvc_rdata = st.int_enables;
				RFX_CR_SVC_TABLE:  next_st.mvc_rdata = st.svc_table;
				RFX_CR_MASK_RET:   next_st.mvc_rdata = st.mask_ret;
				RFX_CR_NMASK_RET:  next_st.mvc_rdata = st.nmask_ret;
				RFX_CR_EXEC_PC:    next_st.mvc_rdata = execute_stage_program_counter;
				default:           next_st.mvc_rdata = 32'h0000_0000;
			endcase
		end
		if (move_control_wr)
		begin
			case (move_control_idx)
				RFX_CR_ADDR_MODE:  next_st.addr_mode = move_control_wdata;
				RFX_CR_CSR:
				begin
					next_st.int_en      = move_control_wdata[RFX_CSR_INT_EN];
					next_st.prev_int_en = move_control_wdata[RFX_CSR_PREV_INT_EN];
					// Software may clear the flag but never set it
					if (!move_control_wdata[RFX_CSR_SATURATE])
						next_st.saturated = 1'b0;
				end
				RFX_CR_INT_SET:    next_st.flag_set_pend = move_control_wdata[15:0];
				RFX_CR_INT_CLEAR:  next_st.flag_clr_pend = move_control_wdata[15:0];
				RFX_CR_INT_ENABLE: next_st.int_enables = move_control_wdata;
				RFX_CR_SVC_TABLE:  next_st.svc_table = move_control_wdata;
				RFX_CR_MASK_RET:   next_st.mask_ret = move_control_wdata;
				RFX_CR_NMASK_RET:  next_st.nmask_ret = move_control_wdata;
				default:           next_st.addr_mode = st.addr_mode;
			endcase
		end
		// Delayed saturation set is applied last so it beats a clear
		if (st.saturate_pend)
			next_st.saturated = 1'b1;

		// Global enable: save on take, restore on return
		if (int_take)
		begin
			next_st.prev_int_en = st.int_en;
			next_st.int_en      = 1'b0;
		end
		else if (return_from_interrupt_branch)
			next_st.int_en = st.prev_int_en;

		// Clears first, then sets, so a new event is never lost
		next_st.int_flags = st.int_flags & ~st.flag_clr_pend;
		if (int_take)
			next_st.int_flags[int_take_num] = 1'b0;
		next_st.int_flags = next_st.int_flags | st.flag_set_pend
			| external_interrupt_pin;
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st         <= '0;
			st.variant <= RFX_CFG_RST;
		end
		else
			st <= next_st;
	end

	assign first_source_data  = st.op1;
	assign second_source_data = st.op2;
	assign cross_stall        = stall;
	assign store_data         = st.st_data;
	assign transfer_addr      = st.da;
	assign move_control_rdata = st.mvc_rdata;
	assign global_int_enable  = st.int_en;
	assign saturation_flag    = st.saturated;

	// ==========================================================
	// Assertions
	property p_side_a_write;
		@(posedge pclk) disable iff (!presetn)
		unit_we[0] && !stall && !load_valid[0]
			|=> st.rf[0][$past(unit_waddr[0])] == $past(unit_wdata[0]);
	endproperty
	a_side_a_write: assert property (p_side_a_write) else $error("side A write lost");

	property p_stall_once;
		@(posedge pclk) disable iff (!presetn)
		stall |=> !stall;
	endproperty
	a_stall_once: assert property (p_stall_once) else $error("stall longer than one cycle");

	property p_stall_hold;
		@(posedge pclk) disable iff (!presetn)
		stall |=> first_source_data == $past(first_source_data);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("operands moved in stall");

	property p_isr_delay;
		@(posedge pclk) disable iff (!presetn)
		move_control_wr && move_control_idx == RFX_CR_INT_SET && move_control_wdata[0]
			|-> ##2 st.int_flags[0];
	endproperty
	a_isr_delay: assert property (p_isr_delay) else $error("flag set missed");

	property p_sat_delay;
		@(posedge pclk) disable iff (!presetn)
		saturation_event |-> ##2 saturation_flag;
	endproperty
	a_sat_delay: assert property (p_sat_delay) else $error("saturation flag missed");

	property p_take_gie;
		@(posedge pclk) disable iff (!presetn)
		int_take |=> !global_int_enable && st.prev_int_en == $past(st.int_en);
	endproperty
	a_take_gie: assert property (p_take_gie) else $error("enable not cleared on take");

	property p_return_gie;
		@(posedge pclk) disable iff (!presetn)
		return_from_interrupt_branch && !int_take && !move_control_wr
			|=> global_int_enable == $past(st.prev_int_en);
	endproperty
	a_return_gie: assert property (p_return_gie) else $error("enable not restored");

	property p_pin_flag;
		@(posedge pclk) disable iff (!presetn)
		external_interrupt_pin[4] |=> st.int_flags[4];
	endproperty
	a_pin_flag: assert property (p_pin_flag) else $error("pin did not set flag");

	c_stall: cover property (@(posedge pclk) disable iff (!presetn) stall);
	c_take:  cover property (@(posedge pclk) disable iff (!presetn) int_take ##1 return_from_interrupt_branch);
	c_dword: cover property (@(posedge pclk) disable iff (!presetn) load_valid[1] && load_double[1] && is_ext);
endmodule // rfx_core

// File: bench/rfx_unit_model.sv
`timescale 1ns/1ps
// ==========================================
// Functional units and load side of the core
module rfx_unit_model
(
	input  wire logic                     pclk,
	input  wire logic                     cross_stall,
	output logic      [7:0]               unit_we,
	output rfx_pkg::rfx_radr_t [7:0]      unit_waddr,
	output rfx_pkg::rfx_word_t [7:0]      unit_wdata,
	output logic      [1:0]               load_valid,
	output logic      [1:0]               load_double,
	output rfx_pkg::rfx_radr_t [1:0]      load_addr,
	output logic      [1:0][63:0]         load_data
);
	import rfx_pkg::*;
	logic stall_seen;

	// Stall judged mid-cycle, where the combinational flag has settled
	always @(negedge pclk) stall_seen <= cross_stall;

	// Idle buses start inverted so nothing stale looks valid
	initial
	begin
		{unit_we, load_valid, load_double} = '0;
		{unit_waddr, unit_wdata, load_addr, load_data} = '1;
	end

	// Unit result write; called at a rising edge, held through stalls
	task automatic unit_wr(input int u, input rfx_radr_t a, input rfx_word_t d);
		unit_we[u] <= 1'b1;
		unit_waddr[u] <= a;
		unit_wdata[u] <= d;
		do
			@(posedge pclk);
		while (stall_seen);
		unit_we[u] <= 1'b0;
		unit_waddr[u] <= ~a;
		unit_wdata[u] <= ~d;
	endtask

	// One load per transfer group at a time, so no shared long port clash
	task automatic load_wr(input int g, input logic dbl, input rfx_radr_t a,
		input logic [63:0] d);
		load_valid[g] <= 1'b1;
		load_double[g] <= dbl;
		load_addr[g] <= a;
		load_data[g] <= d;
		do
			@(posedge pclk);
		while (stall_seen);
		load_valid[g] <= 1'b0;
		load_addr[g] <= ~a;
		load_data[g] <= ~d;
	endtask
endmodule // rfx_unit_model

// File: bench/rfx_core_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
	$display("CHECK FAILED %0t got %0h", $time, a); end end
// ==========================================
// Bench top
module rfx_core_tb_top;
	import rfx_pkg::*;
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, cross_stall, slv_err;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, move_control_rdata, execute_stage_program_counter;
	logic [31:0]      move_control_wdata, rd_data;
	logic [7:0]       first_source_cross, second_source_cross, unit_we;
	rfx_radr_t [7:0]  first_source_addr, second_source_addr, unit_waddr;
	rfx_word_t [7:0]  first_source_data, second_source_data, unit_wdata;
	logic [1:0]       load_valid, load_double, store_double, transfer_unit_sel;
	rfx_radr_t [1:0]  load_addr, store_addr;
	logic [1:0][63:0] load_data, store_data;
	rfx_word_t [1:0]  data_unit_addr, transfer_addr;
	logic             move_control_wr, move_control_rd, int_take, return_from_interrupt_branch;
	logic             saturation_event, global_int_enable, saturation_flag;
	logic [3:0]       move_control_idx, int_take_num;
	logic [15:0]      external_interrupt_pin;
	int               err_count, total_checks;

	rfx_core u_rfx_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .unit_we, .unit_waddr, .unit_wdata, .first_source_addr,
		.second_source_addr, .first_source_cross, .second_source_cross, .first_source_data,
		.second_source_data, .cross_stall, .load_valid, .load_double, .load_addr, .load_data,
		.store_addr, .store_double, .store_data, .data_unit_addr, .transfer_unit_sel,
		.transfer_addr, .move_control_wr, .move_control_rd, .move_control_idx,
		.move_control_wdata, .move_control_rdata, .external_interrupt_pin, .int_take,
		.int_take_num, .return_from_interrupt_branch, .saturation_event,
		.execute_stage_program_counter, .global_int_enable, .saturation_flag);
	rfx_unit_model u_rfx_unit_model (.pclk, .cross_stall, .unit_we, .unit_waddr, .unit_wdata,
		.load_valid, .load_double, .load_addr, .load_data);

	// 250 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ==========================================
	// Bus tasks; all start and end on a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// APB transfer; one idle cycle after, so psel never toggles twice in a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd_data = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Move-control access; read data lands one cycle after the request
	task automatic move_control_instr(input logic w, input logic [3:0] i, input logic [31:0] d);
		move_control_idx <= i;
		move_control_wdata <= d;
		if (w) move_control_wr <= 1'b1;
		else move_control_rd <= 1'b1;
		@(posedge pclk);
		if (w) move_control_wr <= 1'b0;
		else move_control_rd <= 1'b0;
		if (!w) @(posedge pclk);
		rd_data = move_control_rdata;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_base();
		apb(0, 12'h010, 32'h0);
		`CHK(slv_err, 1'b1)
		`CHK(rd_data, 32'h0)
		u_rfx_unit_model.unit_wr(0, 5'h3, 32'haaaa0003);
		u_rfx_unit_model.unit_wr(4, 5'h3, 32'hbbbb0003);
		first_source_addr <= {8{5'h3}};
		second_source_addr <= {8{5'h3}};
		first_source_cross <= 8'h10;
		second_source_cross <= 8'h04;
		tick(2);
		`CHK(first_source_data[1], 32'haaaa0003)
		`CHK(first_source_data[5], 32'hbbbb0003)
		`CHK(first_source_data[4], 32'haaaa0003)
		`CHK(second_source_data[2], 32'hbbbb0003)
		// Data unit has no cross access here, so it still sees its own file
		first_source_cross <= 8'h00;
		second_source_cross <= 8'h08;
		tick(2);
		`CHK(second_source_data[3], 32'haaaa0003)
		// Two side A cross readers of different registers
		first_source_cross <= 8'h01;
		second_source_cross <= 8'h04;
		second_source_addr[2] <= 5'h4;
		tick(2);
		first_source_cross <= 8'h00;
		second_source_cross <= 8'h00;
		tick(1);
		apb(0, RFX_OFF_STATUS, 32'h0);
		`CHK(rd_data[0], 1'b1)
		apb(1, RFX_OFF_STATUS, 32'h3);
		apb(0, RFX_OFF_STATUS, 32'h0);
		`CHK(rd_data, 32'h0)
	endtask

	task automatic t_ext();
		apb(1, RFX_OFF_CFG, 32'h2);
		apb(0, RFX_OFF_CFG, 32'h0);
		`CHK(rd_data, 32'h2)
		second_source_addr <= {8{5'h3}};
		second_source_cross <= 8'hff;
		tick(2);
		for (int u = 0; u < 8; u++)
			`CHK(second_source_data[u], (u < 4) ? 32'hbbbb0003 : 32'haaaa0003)
		second_source_cross <= 8'h00;
		u_rfx_unit_model.unit_wr(4, 5'h7, 32'hd00d0007);
		second_source_addr[1] <= 5'h7;
		second_source_cross <= 8'h02;
		tick(1);
		`CHK(cross_stall, 1'b1)
		tick(1);
		`CHK(cross_stall, 1'b0)
		tick(1);
		`CHK(second_source_data[1], 32'hd00d0007)
		u_rfx_unit_model.load_wr(1, 1'b0, 5'h7, 64'h1d);
		tick(1);
		`CHK(cross_stall, 1'b0)
		tick(1);
		`CHK(second_source_data[1], 32'h1d)
		second_source_cross <= 8'h00;
		apb(0, RFX_OFF_STALLS, 32'h0);
		`CHK(rd_data, 32'h1)
	endtask

	task automatic t_mem();
		apb(1, RFX_OFF_CFG, 32'h1);
		u_rfx_unit_model.load_wr(0, 1'b1, 5'h2, 64'h11112222_33334444);
		first_source_addr[0] <= 5'h2;
		second_source_addr[0] <= 5'h3;
		tick(2);
		`CHK(first_source_data[0], 32'h33334444)
		`CHK(second_source_data[0], 32'h11112222)
		store_addr[0] <= 5'h2;
		store_double[0] <= 1'b1;
		apb(1, RFX_OFF_CFG, 32'h2);
		// Store word is built from the variant of the cycle before
		tick(1);
		`CHK(store_data[0], 64'h11112222_33334444)
		apb(1, RFX_OFF_CFG, 32'h0);
		tick(1);
		`CHK(store_data[0], 64'h33334444)
		// Base ignores the doubleword flag: only the even register is written
		u_rfx_unit_model.load_wr(1, 1'b1, 5'h8, 64'h55556666_77778888);
		first_source_addr[4] <= 5'h8;
		second_source_addr[4] <= 5'h9;
		data_unit_addr <= {32'h000000b0, 32'h000000a0};
		transfer_unit_sel <= 2'b01;
		tick(2);
		`CHK(first_source_data[4], 32'h77778888)
		`CHK(second_source_data[4], 32'h0)
		`CHK(transfer_addr[0], 32'h000000b0)
		`CHK(transfer_addr[1], 32'h000000a0)
	endtask

	task automatic t_ctrl();
		move_control_instr(1, RFX_CR_INT_SET, 32'h8);
		move_control_instr(0, RFX_CR_INT_FLAG, 32'h0);
		`CHK(rd_data, 32'h0)
		move_control_instr(0, RFX_CR_INT_FLAG, 32'h0);
		`CHK(rd_data, 32'h8)
		move_control_instr(1, RFX_CR_INT_CLEAR, 32'h8);
		external_interrupt_pin <= 16'h0020;
		tick(1);
		external_interrupt_pin <= 16'h0000;
		move_control_instr(0, RFX_CR_INT_FLAG, 32'h0);
		`CHK(rd_data, 32'h20)
		move_control_instr(0, RFX_CR_EXEC_PC, 32'h0);
		`CHK(rd_data, 32'h00001234)
		move_control_instr(1, RFX_CR_CSR, 32'h1);
		int_take <= 1'b1;
		int_take_num <= 4'h5;
		tick(1);
		`CHK(global_int_enable, 1'b1)
		int_take <= 1'b0;
		tick(1);
		`CHK(global_int_enable, 1'b0)
		move_control_instr(0, RFX_CR_INT_FLAG, 32'h0);
		`CHK(rd_data, 32'h0)
		return_from_interrupt_branch <= 1'b1;
		tick(1);
		return_from_interrupt_branch <= 1'b0;
		tick(1);
		`CHK(global_int_enable, 1'b1)
		saturation_event <= 1'b1;
		tick(1);
		saturation_event <= 1'b0;
		tick(1);
		`CHK(saturation_flag, 1'b0)
		saturation_event <= 1'b1;
		tick(1);
		`CHK(saturation_flag, 1'b1)
		// A clear landing on the same edge as a pending set loses
		saturation_event <= 1'b0;
		move_control_instr(1, RFX_CR_CSR, 32'h1);
		tick(1);
		`CHK(saturation_flag, 1'b1)
		move_control_instr(1, RFX_CR_CSR, 32'h1);
		tick(1);
		`CHK(saturation_flag, 1'b0)
	endtask

	// ==========================================
	// Verdict, shared by the main sequence and the watchdog
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	initial
	begin
		#20000;
		err_count++;
		close_out();
	end

	// Main sequence
	initial
	begin
		{psel, penable, pwrite, move_control_wr, move_control_rd, int_take} = '0;
		{return_from_interrupt_branch, saturation_event, store_double, transfer_unit_sel} = '0;
		{paddr, pwdata, first_source_addr, second_source_addr, first_source_cross} = '0;
		{second_source_cross, store_addr, data_unit_addr, move_control_idx, int_take_num} = '0;
		{external_interrupt_pin, move_control_wdata} = '0;
		execute_stage_program_counter = 32'h00001234;
		presetn = 1'b0;
		tick(3);
		presetn <= 1'b1;
		apb(0, RFX_OFF_CFG, 32'h0);
		`CHK(rd_data, 32'h0)
		t_base();
		t_ext();
		t_mem();
		t_ctrl();
		close_out();
	end
endmodule // rfx_core_tb_top
